// ---- src/isw_host_pkg.sv ----
// shared constants, types and crc helpers for the isolated switch host interface
package isw_host_pkg;

	// core clock and reset-hold timing
	localparam int CORE_CLK_HZ = 25_000_000;
	localparam int RESET_HOLD_US = 100; // cs low with latch strobe high, microseconds
	localparam int RESET_HOLD_CYC = (CORE_CLK_HZ / 1_000_000) * RESET_HOLD_US;
	localparam int HOLD_CNT_W = 12;

	// register addressing
	localparam int ADDR_WRITE_BIT = 7; // msb set selects a write
	localparam logic [6:0] DRIVE_ADDR = 7'h00; // output drive register index
	localparam logic [7:0] ADDR_RESET = {1'b1, DRIVE_ADDR}; // preset targets drive writes

	// crc engine
	localparam logic [4:0] CRC_POLY = 5'h15; // x^5+x^4+x^2+1 without the x^5 term
	localparam logic [4:0] CRC_INIT = 5'h1F; // working register preset
	localparam int CRC_W = 5;
	localparam int CRC_SEG_BITS = 16; // mode 1 restart period
	localparam int M1_PAYLOAD = 11;
	localparam int M3_PAYLOAD = 19;

	// frame lengths per serial mode
	localparam int MODE0_BITS = 8;
	localparam int MODE1_BITS = 16;
	localparam int MODE2_BITS = 16;
	localparam int MODE3_BITS = 24;
	localparam int SHIFT_W = 24;
	localparam int CNT_W = 8; // wraps at 256, a multiple of 8, so modulo checks survive
	localparam int FETCH_BIT = 8; // mode 3 address complete after this many bits

	// serial framing modes, one-hot
	typedef enum logic [3:0] {
		SER_MODE0 = 4'b0001,
		SER_MODE1 = 4'b0010,
		SER_MODE2 = 4'b0100,
		SER_MODE3 = 4'b1000
	} ser_mode_type;

	// serial link state, one-hot
	typedef enum logic [1:0] {
		LINK_IDLE = 2'b01,
		LINK_FRAME = 2'b10
	} link_state_type;

	// pins arriving from outside the core clock domain
	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic ale;
		logic sel;
		logic fmt_lo;
		logic fmt_hi;
		logic sclk;
		logic sdi;
		logic [7:0] bus;
	} pin_in_type;

	// idle levels of the pins, matching their pulls
	localparam pin_in_type PIN_RESET = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, ale: 1'b0,
		sel: 1'b0, fmt_lo: 1'b0, fmt_hi: 1'b0, sclk: 1'b0, sdi: 1'b0, bus: 8'h00};

	// status flags returned in serial frames
	typedef struct packed {
		logic [7:0] summary;
		logic low;
		logic missing;
		logic common;
	} status_type;

	// one crc step, message bit first into the top
	function automatic logic [4:0] crc5_step(input logic [4:0] c, input logic b);
		logic fb;
		fb = c[4] ^ b;
		return {c[3:0], 1'b0} ^ (fb ? CRC_POLY : 5'h00);
	endfunction

	// crc over the top n bits of a left-aligned word
	function automatic logic [4:0] crc5_over(input logic [23:0] d, input int n);
		logic [4:0] c;
		c = CRC_INIT;
		for (int i = 0; i < SHIFT_W; i++) begin
			if (i < n) begin
				c = crc5_step(c, d[SHIFT_W-1-i]);
			end
		end
		return c;
	endfunction

	// frame length of a serial mode
	function automatic int frame_bits(input ser_mode_type m);
		case (m)
			SER_MODE0: return MODE0_BITS;
			SER_MODE1: return MODE1_BITS;
			SER_MODE2: return MODE2_BITS;
			default: return MODE3_BITS;
		endcase
	endfunction

	// outgoing frame, left aligned, signature appended where the mode has one
	function automatic logic [23:0] build_resp(input ser_mode_type m, input status_type s,
		input logic [7:0] d);
		logic [23:0] r;
		logic [10:0] p11;
		logic [18:0] p19;
		p11 = {s.summary, s.low, s.missing, s.common};
		p19 = {s.summary, d, s.low, s.missing, s.common};
		case (m)
			SER_MODE0: r = {s.summary, 16'h0000};
			SER_MODE1: r = {p11, crc5_over({p11, 13'h0000}, M1_PAYLOAD), 8'h00};
			SER_MODE2: r = {s.summary, d, 8'h00};
			SER_MODE3: r = {p19, crc5_over({p19, 5'h00}, M3_PAYLOAD)};
			default: r = 24'h000000;
		endcase
		return r;
	endfunction

endpackage

// ---- src/pin_sync.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 17,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] clean_o
);

	logic [WIDTH-1:0] stage1_q; // metastability catcher, read only by stage2
	logic [WIDTH-1:0] stage2_q;
	logic [WIDTH-1:0] stage3_q;
	logic [WIDTH-1:0] clean_q; // accepted level
	logic [WIDTH-1:0] clean_d;

	// a bit changes only once stages two and three agree
	for (genvar i = 0; i < WIDTH; i++) begin : g_agree
		assign clean_d[i] = (stage2_q[i] == stage3_q[i]) ? stage3_q[i] : clean_q[i];
	end

	// shift chain and filter register
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			stage1_q <= INIT;
			stage2_q <= INIT;
			stage3_q <= INIT;
			clean_q <= INIT;
		end else begin
			stage1_q <= async_i;
			stage2_q <= stage1_q;
			stage3_q <= stage2_q;
			clean_q <= clean_d;
		end
	end

	assign clean_o = clean_q;

endmodule

// ---- src/isolated_switch_host_interface.sv ----
// host interface of the isolated eight-channel switch: parallel, direct and serial modes
// Operation
// - select low parallel, select high serial
// - bus floats while cs, rd, wr high
// - direct mode copies bus bits to outputs
// - direct mode: faults reported live, unlatched
// - address preset msb one, targets drive
// - serial output floats while cs high
// - sample input on sclk rise, 8/16/24 bits
// - next output bit on each sclk fall
// - two format pins pick serial mode 0-3
// - clock count not multiple of 8 fails
// - mode 1 crc restarts every 16 clocks
// - chain passes data one, two or three bytes late
// - crc5 poly x5+x4+x2+1, preset all ones
// - crc covers 11 or 19 payload bits
// - mode 1 writes drive, returns status
// - mode 3 write frame and its reply
// - mode 3 read frame returns register data
// - all 24 bits must leave zero remainder
// - checks only while selected, report at cs rise
// - latch strobe captures address, data hits it
// - cs low, strobe high 100 us resets
// - data valid at strobe rising edges
`timescale 1ns/1ps
module isolated_switch_host_interface (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic iface_sel_i, // low parallel, high serial
	input wire logic cs_n_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic ale_i,
	input wire logic [7:0] addr_data_bus_i,
	output logic [7:0] addr_data_bus_o,
	output logic addr_data_bus_oe_n_o,
	input wire logic sclk_i,
	input wire logic sdi_i,
	output logic sdo_o,
	output logic sdo_oe_n_o,
	input wire logic serial_format_sel_lo_i,
	input wire logic serial_format_sel_hi_i,
	output logic frame_check_fail_n_o,
	input wire logic [7:0] channel_fault_summary_i,
	input wire logic supply_low_flag_i,
	input wire logic supply_missing_flag_i,
	input wire logic common_fault_flag_i,
	output logic common_fault_n_o,
	output logic [7:0] power_outputs_o,
	output logic [6:0] reg_addr_o,
	output logic reg_rd_o,
	input wire logic [7:0] reg_rd_data_i,
	output logic reg_wr_o,
	output logic [7:0] reg_wr_data_o
);
	import isw_host_pkg::*;

	pin_in_type pin_raw; // raw pins bundled for the synchroniser
	pin_in_type pin; // filtered pins
	pin_in_type prev_q; // filtered pins one cycle ago
	status_type st; // status flags for serial replies

	assign pin_raw = '{cs_n: cs_n_i, rd_n: rd_n_i, wr_n: wr_n_i, ale: ale_i, sel: iface_sel_i,
		fmt_lo: serial_format_sel_lo_i, fmt_hi: serial_format_sel_hi_i, sclk: sclk_i,
		sdi: sdi_i, bus: addr_data_bus_i};
	assign st = '{summary: channel_fault_summary_i, low: supply_low_flag_i,
		missing: supply_missing_flag_i, common: common_fault_flag_i};

	// every pin goes through the same filter so sdi keeps step with sclk
	pin_sync #(
		.WIDTH($bits(pin_in_type)),
		.INIT(PIN_RESET)
	) u_pin_sync (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.async_i(pin_raw),
		.clean_o(pin)
	);

	// device reset by holding cs low with the latch strobe high
	logic [HOLD_CNT_W-1:0] hold_cnt_q;
	logic [HOLD_CNT_W-1:0] hold_cnt_d;
	logic soft_rst_q;
	logic soft_rst_d;
	logic rst_all; // pin reset or power-on reset

	always_comb begin
		hold_cnt_d = hold_cnt_q;
		soft_rst_d = 1'b0;
		if (!pin.cs_n && pin.ale) begin
			// saturate so one long hold gives one reset pulse
			if (hold_cnt_q == HOLD_CNT_W'(RESET_HOLD_CYC - 1)) begin
				soft_rst_d = 1'b1;
				hold_cnt_d = HOLD_CNT_W'(RESET_HOLD_CYC);
			end else if (hold_cnt_q < HOLD_CNT_W'(RESET_HOLD_CYC)) begin
				hold_cnt_d = hold_cnt_q + HOLD_CNT_W'(1);
			end
		end else begin
			hold_cnt_d = '0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			hold_cnt_q <= '0;
			soft_rst_q <= 1'b0;
		end else begin
			hold_cnt_q <= hold_cnt_d;
			soft_rst_q <= soft_rst_d;
		end
	end

	assign rst_all = srst_i | soft_rst_q;

	// edges and mode decode from filtered pins
	logic sclk_rise;
	logic sclk_fall;
	logic wr_rise;
	logic par_mode;
	logic direct_mode;
	logic par_read;
	ser_mode_type cur_mode;
	logic [7:0] addr_q; // internal address register, read by the bus decode below
	logic [7:0] addr_d;

	assign sclk_rise = pin.sclk & ~prev_q.sclk;
	assign sclk_fall = ~pin.sclk & prev_q.sclk;
	assign wr_rise = pin.wr_n & ~prev_q.wr_n;
	assign par_mode = ~pin.sel;
	// cs, wr and strobe low with rd high: bus flows to outputs
	assign direct_mode = par_mode & ~pin.cs_n & ~pin.wr_n & ~pin.ale & pin.rd_n;
	// bus is driven only during a valid read, so it floats otherwise
	assign par_read = par_mode & ~pin.cs_n & ~pin.rd_n & ~pin.ale & ~addr_q[ADDR_WRITE_BIT];

	// format pins pick the framing
	always_comb begin
		case ({pin.fmt_hi, pin.fmt_lo})
			2'b00: cur_mode = SER_MODE0;
			2'b01: cur_mode = SER_MODE1;
			2'b10: cur_mode = SER_MODE2;
			2'b11: cur_mode = SER_MODE3;
			default: cur_mode = SER_MODE0;
		endcase
	end

	// main interface state
	link_state_type link_q;
	link_state_type link_d;
	ser_mode_type mode_q; // framing latched at cs fall
	ser_mode_type mode_d;
	logic [SHIFT_W-1:0] sh_q; // shared in/out shift register
	logic [SHIFT_W-1:0] sh_d;
	logic [CNT_W-1:0] cnt_q; // sclk rises this frame
	logic [CNT_W-1:0] cnt_d;
	logic [CRC_W-1:0] crc_q; // running receive crc
	logic [CRC_W-1:0] crc_d;
	logic sdo_q;
	logic sdo_d;
	logic fail_q; // sticky frame failure
	logic fail_d;
	logic fetch_q; // mode 3 read data due
	logic fetch_d;
	logic [7:0] drive_q; // output drive register
	logic [7:0] drive_d;
	logic wr_q;
	logic wr_d;
	logic [7:0] wr_data_q;
	logic [7:0] wr_data_d;
	logic [7:0] rd_data_q;
	logic [7:0] rd_data_d;
	logic fault_n_q;
	logic fault_n_d;

	// helper values for the frame engine
	int frame_len;
	logic sh_top;
	logic [CRC_W-1:0] crc_base;
	logic frame_bad;
	logic [7:0] frm_addr;
	logic [7:0] frm_data;
	logic [23:0] start_resp;
	logic [23:0] fetch_resp;
	logic start_mode2;

	assign frame_len = frame_bits(mode_q);
	assign sh_top = sh_q[frame_len-1]; // frame length sets the chain delay
	// mode 1 restarts at each 16-bit segment boundary
	assign crc_base = (mode_q == SER_MODE1 && cnt_q[3:0] == 4'h0) ? CRC_INIT : crc_q;
	assign frame_bad = (cnt_q[2:0] != 3'h0) ||
		((mode_q == SER_MODE1 || mode_q == SER_MODE3) && crc_q != 5'h00);
	assign frm_addr = (mode_q == SER_MODE3) ? sh_q[23:16] : sh_q[15:8];
	assign frm_data = (mode_q == SER_MODE3) ? sh_q[15:8] : sh_q[7:0];
	// mode 3 write replies carry dummy data; read data is patched in later
	assign start_resp = build_resp(cur_mode, st,
		(cur_mode == SER_MODE3) ? 8'h00 : reg_rd_data_i);
	assign fetch_resp = build_resp(SER_MODE3, st, reg_rd_data_i);
	assign start_mode2 = pin.sel & ~pin.cs_n & (link_q == LINK_IDLE) & (cur_mode == SER_MODE2);

	always_comb begin
		link_d = link_q;
		mode_d = mode_q;
		sh_d = sh_q;
		cnt_d = cnt_q;
		crc_d = crc_q;
		sdo_d = sdo_q;
		fail_d = fail_q;
		fetch_d = 1'b0;
		addr_d = addr_q;
		drive_d = drive_q;
		wr_d = 1'b0;
		wr_data_d = wr_data_q;
		rd_data_d = rd_data_q;
		if (pin.sel) begin
			case (link_q)
				LINK_IDLE: begin
					// unselected: sclk toggles are ignored entirely
					if (!pin.cs_n) begin
						link_d = LINK_FRAME;
						mode_d = cur_mode;
						cnt_d = '0;
						crc_d = CRC_INIT;
						sh_d = start_resp >> (SHIFT_W - frame_bits(cur_mode));
						sdo_d = start_resp[SHIFT_W-1];
					end
				end
				LINK_FRAME: begin
					if (pin.cs_n) begin
						link_d = LINK_IDLE;
						// judged only at cs rise; an empty frame changes nothing
						if (cnt_q != '0) begin
							fail_d = frame_bad;
							if (!frame_bad) begin
								case (mode_q)
									SER_MODE0: drive_d = sh_q[7:0];
									SER_MODE1: drive_d = sh_q[15:8];
									default: begin
										addr_d = frm_addr;
										if (frm_addr[ADDR_WRITE_BIT]) begin
											wr_d = 1'b1;
											wr_data_d = frm_data;
											if (frm_addr[6:0] == DRIVE_ADDR) begin
												drive_d = frm_data;
											end
										end
									end
								endcase
							end
						end
					end else begin
						// read data arrives one cycle after the address completes
						if (fetch_q) begin
							sh_d[23:8] = fetch_resp[15:0];
						end
						if (sclk_rise) begin
							sh_d = {sh_q[SHIFT_W-2:0], pin.sdi};
							cnt_d = cnt_q + CNT_W'(1);
							crc_d = crc5_step(crc_base, pin.sdi);
							if (mode_q == SER_MODE3 && cnt_d == CNT_W'(FETCH_BIT) &&
								!sh_d[ADDR_WRITE_BIT]) begin
								fetch_d = 1'b1;
								addr_d = sh_d[7:0];
							end
						end
						if (sclk_fall) begin
							sdo_d = sh_top;
						end
					end
				end
				default: link_d = LINK_IDLE;
			endcase
		end else begin
			link_d = LINK_IDLE;
			// address phase: strobe high, both strobes idle
			if (!pin.cs_n && pin.ale && pin.rd_n && pin.wr_n) begin
				addr_d = pin.bus;
			end
			// write completes at the rising write strobe
			if (wr_rise && !pin.cs_n && !pin.ale && addr_q[ADDR_WRITE_BIT]) begin
				wr_d = 1'b1;
				wr_data_d = pin.bus;
				if (addr_q[6:0] == DRIVE_ADDR) begin
					drive_d = pin.bus;
				end
			end
			// direct mode relies on the preset address aiming at drive
			if (direct_mode && addr_q == ADDR_RESET) begin
				drive_d = pin.bus;
			end
			// refreshed every cycle so data is steady at the rd rising edge
			if (par_read) begin
				rd_data_d = reg_rd_data_i;
			end
		end
		// live, unlatched fault summary; common fault only in parallel modes
		fault_n_d = ~(|st.summary | st.low | st.missing | (par_mode & st.common));
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_all) begin
			prev_q <= PIN_RESET;
			link_q <= LINK_IDLE;
			mode_q <= SER_MODE0;
			sh_q <= '0;
			cnt_q <= '0;
			crc_q <= CRC_INIT;
			sdo_q <= 1'b0;
			fail_q <= 1'b0;
			fetch_q <= 1'b0;
			addr_q <= ADDR_RESET;
			drive_q <= 8'h00;
			wr_q <= 1'b0;
			wr_data_q <= 8'h00;
			rd_data_q <= 8'h00;
			fault_n_q <= 1'b1;
		end else begin
			prev_q <= pin;
			link_q <= link_d;
			mode_q <= mode_d;
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			crc_q <= crc_d;
			sdo_q <= sdo_d;
			fail_q <= fail_d;
			fetch_q <= fetch_d;
			addr_q <= addr_d;
			drive_q <= drive_d;
			wr_q <= wr_d;
			wr_data_q <= wr_data_d;
			rd_data_q <= rd_data_d;
			fault_n_q <= fault_n_d;
		end
	end

	assign addr_data_bus_o = rd_data_q;
	assign addr_data_bus_oe_n_o = ~par_read;
	assign sdo_o = sdo_q;
	assign sdo_oe_n_o = (link_q != LINK_FRAME);
	assign frame_check_fail_n_o = ~fail_q;
	assign common_fault_n_o = fault_n_q;
	assign power_outputs_o = drive_q;
	assign reg_addr_o = addr_q[6:0];
	assign reg_rd_o = par_read | fetch_q | start_mode2;
	assign reg_wr_o = wr_q;
	assign reg_wr_data_o = wr_data_q;

	// checks on the interface logic
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_all);

	logic cs_rise_ser; // frame end seen by the engine
	assign cs_rise_ser = pin.sel && pin.cs_n && link_q == LINK_FRAME && cnt_q != '0;

	iface_select_a: assert property (pin.sel |-> addr_data_bus_oe_n_o)
		else $error("parallel bus driven in serial mode");
	bus_float_a: assert property ((pin.cs_n && pin.rd_n && pin.wr_n) |-> addr_data_bus_oe_n_o)
		else $error("parallel bus driven while idle");
	direct_copy_a: assert property ((direct_mode && addr_q == ADDR_RESET) |=>
		power_outputs_o == $past(pin.bus))
		else $error("direct mode output not following bus");
	addr_preset_a: assert property ($past(rst_all) |-> addr_q == ADDR_RESET)
		else $error("address not preset after reset");
	sdo_float_a: assert property ((pin.cs_n && prev_q.cs_n) |-> sdo_oe_n_o)
		else $error("serial output driven while deselected");
	sample_shift_a: assert property ((sclk_rise && link_q == LINK_FRAME && !pin.cs_n) |=>
		sh_q[0] == $past(pin.sdi) && cnt_q == $past(cnt_q) + CNT_W'(1))
		else $error("serial input not sampled on rise");
	sdo_update_a: assert property ((sclk_fall && link_q == LINK_FRAME && !pin.cs_n) |=>
		sdo_o == $past(sh_top))
		else $error("serial output not updated on fall");
	count_fail_a: assert property ((cs_rise_ser && cnt_q[2:0] != 3'h0) |=>
		!frame_check_fail_n_o [*2])
		else $error("bad clock count not flagged");
	crc_fail_a: assert property ((cs_rise_ser && mode_q == SER_MODE3 && crc_q != 5'h00) |=>
		!frame_check_fail_n_o)
		else $error("bad signature not flagged");
	// a reset also clears the flag, so the cycle after one is left out
	fail_moment_a: assert property ((!$past(rst_all) && fail_q != $past(fail_q)) |->
		$past(cs_rise_ser))
		else $error("fail flag changed outside cs rise");
	fail_sticky_a: assert property ((fail_q && !cs_rise_ser) |=> fail_q)
		else $error("fail flag released without a clean frame");
	reset_hold_a: assert property ((!pin.cs_n && pin.ale &&
		hold_cnt_q == HOLD_CNT_W'(RESET_HOLD_CYC - 1)) |=> soft_rst_q)
		else $error("hold reset not issued");

	direct_seen_c: cover property (direct_mode && addr_q == ADDR_RESET);
	par_write_c: cover property (par_mode && wr_q);
	mode3_clean_c: cover property (cs_rise_ser && mode_q == SER_MODE3 && !frame_bad);
	mode1_chain_c: cover property (cs_rise_ser && mode_q == SER_MODE1 && cnt_q == CNT_W'(32));

endmodule

// ---- tb/host_model.sv ----
// host model: drives parallel strobes and frames serial transfers
`timescale 1ns/1ps
module host_model (
	input wire logic core_clk_i,
	input wire logic sdo_i,
	input wire logic sdo_oe_n_i,
	input wire logic [7:0] bus_i, // resolved bus level
	output logic cs_n_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic ale_o,
	output logic sclk_o,
	output logic sdi_o,
	output logic [7:0] bus_o
);
	logic oe_seen; // serial output enable seen inside the last frame
	// idle levels follow the pin pulls
	initial begin
		{cs_n_o, rd_n_o, wr_n_o, ale_o, sclk_o, sdi_o} = 6'b111000;
		bus_o = 8'h00;
		oe_seen = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask
	// msb-first frame of n bits; 4 clocks a half period gives 320 ns
	// one frame at most 32 bits: up to four chained 8-bit devices
	task automatic spi(input logic [31:0] tx, input int n, output logic [31:0] rx);
		rx = 32'h0;
		cs_n_o <= 1'b0;
		tick(8);
		for (int i = n - 1; i >= 0; i--) begin
			sdi_o <= tx[i]; // stable around the rise
			tick(4);
			sclk_o <= 1'b1;
			tick(4);
			rx = {rx[30:0], sdo_i}; // bit put out after the previous fall
			oe_seen = sdo_oe_n_i;
			sclk_o <= 1'b0;
		end
		tick(8);
		cs_n_o <= 1'b1;
		sdi_o <= 1'b0; // released: pull-down level
		tick(8);
	endtask
	// clock pulses while deselected, must be ignored
	task automatic stray();
		repeat (3) begin
			sclk_o <= 1'b1;
			tick(4);
			sclk_o <= 1'b0;
			tick(4);
		end
	endtask
	// address phase then one strobe; levels held 8 clocks each
	task automatic par(input logic [7:0] a, input logic [7:0] d, input logic rd,
		output logic [7:0] q);
		cs_n_o <= 1'b0;
		ale_o <= 1'b1;
		bus_o <= a; // msb picks read or write
		tick(8);
		ale_o <= 1'b0; // latched address kept for the data phase
		tick(8);
		if (rd) begin
			rd_n_o <= 1'b0;
			bus_o <= ~a;
		end else begin
			wr_n_o <= 1'b0;
			bus_o <= d;
		end
		tick(8);
		q = bus_i; // read data taken at the strobe rise
		rd_n_o <= 1'b1;
		wr_n_o <= 1'b1; // write data still held at the rise
		tick(8);
		cs_n_o <= 1'b1;
		bus_o <= ~bus_o; // released: inverse of last value
		tick(8);
	endtask
	// strapped direct mode: select, write, latch low, read high
	task automatic direct(input logic [7:0] d);
		{cs_n_o, wr_n_o, ale_o, rd_n_o} <= 4'b0001;
		bus_o <= d;
		tick(8);
	endtask
	// leave direct mode
	task automatic idle();
		wr_n_o <= 1'b1;
		tick(8);
		cs_n_o <= 1'b1;
		tick(8);
	endtask
	// select low with latch strobe high for n clocks
	task automatic hold(input int n);
		cs_n_o <= 1'b0;
		ale_o <= 1'b1;
		bus_o <= 8'h80; // strobe stays high past the reset, so this address is latched again
		tick(n);
		{cs_n_o, ale_o} <= 2'b10;
		tick(8);
	endtask
endmodule

// ---- tb/isolated_switch_host_interface_tb.sv ----
// self-checking bench for the isolated switch host interface
`timescale 1ns/1ps
module isolated_switch_host_interface_tb;
	logic core_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic iface_sel = 1'b0; // low parallel, high serial
	logic fmt_lo = 1'b0;
	logic fmt_hi = 1'b0;
	logic low = 1'b0;
	logic missing = 1'b0;
	logic common = 1'b0;
	logic [7:0] summary = 8'h00;
	logic cs_n, rd_n, wr_n, ale, sclk, sdi, sdo, sdo_oe_n, fail_n, cf_n, bus_oe_n, reg_rd, reg_wr;
	logic [7:0] host_bus, dev_bus, bus, pwr, reg_wr_data;
	logic [6:0] reg_addr;
	logic [7:0] regs [128]; // register file behind the core
	int n_fail = 0;
	int cmp_count = 0;
	int rd_cnt = 0; // cycles with the register read strobe high
	assign bus = bus_oe_n ? host_bus : dev_bus; // device wins while enabled
	initial forever #20 core_clk_i = ~core_clk_i;
	initial foreach (regs[i]) regs[i] = 8'h00;
	// register writes land on the pulse
	always @(posedge core_clk_i) if (reg_wr) regs[reg_addr] <= reg_wr_data;
	always @(posedge core_clk_i) if (reg_rd) rd_cnt <= rd_cnt + 1;
	isolated_switch_host_interface u_isolated_switch_host_interface (.core_clk_i(core_clk_i),
		.srst_i(srst_i), .iface_sel_i(iface_sel), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
		.ale_i(ale), .addr_data_bus_i(bus), .addr_data_bus_o(dev_bus),
		.addr_data_bus_oe_n_o(bus_oe_n), .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo),
		.sdo_oe_n_o(sdo_oe_n), .serial_format_sel_lo_i(fmt_lo), .serial_format_sel_hi_i(fmt_hi),
		.frame_check_fail_n_o(fail_n), .channel_fault_summary_i(summary),
		.supply_low_flag_i(low), .supply_missing_flag_i(missing), .common_fault_flag_i(common),
		.common_fault_n_o(cf_n), .power_outputs_o(pwr), .reg_addr_o(reg_addr), .reg_rd_o(reg_rd),
		.reg_rd_data_i(regs[reg_addr]), .reg_wr_o(reg_wr), .reg_wr_data_o(reg_wr_data));
	host_model u_host_model (.core_clk_i(core_clk_i), .sdo_i(sdo), .sdo_oe_n_i(sdo_oe_n),
		.bus_i(bus), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .ale_o(ale), .sclk_o(sclk),
		.sdi_o(sdi), .bus_o(host_bus));
	// reference signature, independent of the design's helpers
	function automatic logic [4:0] crc_of(input logic [31:0] v, input int n);
		logic [4:0] c;
		c = 5'h1F;
		for (int i = n - 1; i >= 0; i--) c = {c[3:0], 1'b0} ^ ((c[4] ^ v[i]) ? 5'h15 : 5'h00);
		return c;
	endfunction
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// fresh random fault inputs
	task automatic flags();
		{summary, low, missing, common} <= 11'($urandom);
	endtask
	task automatic mode(input logic [1:0] m);
		{fmt_hi, fmt_lo} <= m; // pins pick the framing mode
		u_host_model.tick(8);
	endtask
	// hang guard
	initial begin
		repeat (100000) @(posedge core_clk_i);
		n_fail++;
		final_report();
	end
	initial begin
		logic [31:0] rx;
		logic [10:0] st;
		logic [7:0] d, e, a, q;
		logic [4:0] c;
		int r0;
		void'($urandom(32'h7287b7ce));
		repeat (20) @(posedge core_clk_i);
		srst_i <= 1'b0;
		u_host_model.tick(8);
		check("fail idle", fail_n, 1'b1);
		check("bus float", bus_oe_n, 1'b1);
		check("sdo float", sdo_oe_n, 1'b1);
		// direct mode straight after reset; faults shown live
		for (int i = 0; i < 4; i++) begin
			d = $urandom;
			flags();
			u_host_model.direct(d);
			check("direct out", pwr, d);
			check("fault pin", cf_n, !(|summary | low | missing | common));
		end
		u_host_model.idle();
		$display("done: direct");
		// write a register, read it back, a write with msb clear is refused
		a = 8'(1 + $urandom % 127);
		d = $urandom;
		u_host_model.par({1'b1, a[6:0]}, d, 1'b0, q);
		u_host_model.par({1'b0, a[6:0]}, 8'h00, 1'b1, q);
		check("par read", q, d);
		d = $urandom;
		u_host_model.par(8'h80, d, 1'b0, q);
		check("par drive", pwr, d);
		u_host_model.par(8'h00, ~d, 1'b0, q);
		check("msb clear write", pwr, d);
		check("bus float after", bus_oe_n, 1'b1);
		$display("done: parallel");
		// mode 0 frames, a short frame, stray clocks, recovery, chain
		iface_sel <= 1'b1;
		mode(2'b00);
		for (int i = 0; i < 3; i++) begin
			d = $urandom;
			flags();
			u_host_model.spi({24'h0, d}, 8, rx);
			check("m0 reply", rx, {24'h0, summary});
			check("m0 drive", pwr, d);
			check("m0 ok", fail_n, 1'b1);
		end
		check("sdo in frame", u_host_model.oe_seen, 1'b0);
		check("sdo idle", sdo_oe_n, 1'b1);
		u_host_model.spi(32'h0, 7, rx);
		check("short frame", fail_n, 1'b0);
		check("short no drive", pwr, d);
		u_host_model.stray();
		check("fail held", fail_n, 1'b0);
		d = $urandom;
		e = $urandom;
		u_host_model.spi({16'h0, e, d}, 16, rx);
		check("m0 chain out", rx[7:0], e);
		check("m0 chain drive", pwr, d);
		check("fail released", fail_n, 1'b1);
		$display("done: mode 0");
		// mode 1: good frame, chained frame, corrupt signature
		mode(2'b01);
		flags();
		u_host_model.tick(1);
		st = {summary, low, missing, common};
		d = $urandom;
		c = crc_of({21'h0, d, 3'b000}, 11);
		u_host_model.spi({16'h0, d, 3'b000, c}, 16, rx);
		check("m1 reply", rx, {16'h0, st, crc_of({21'h0, st}, 11)});
		check("m1 drive", pwr, d);
		e = $urandom;
		c = crc_of({21'h0, e, 3'b000}, 11);
		q = $urandom;
		u_host_model.spi({q, 8'hA5, e, 3'b000, c}, 32, rx);
		check("m1 chain out", rx[15:0], {q, 8'hA5});
		check("m1 segment", fail_n, 1'b1);
		check("m1 chain drive", pwr, e);
		u_host_model.spi({16'h0, e, 3'b000, c ^ 5'h01}, 16, rx);
		check("m1 bad crc", fail_n, 1'b0);
		check("m1 refused", pwr, e);
		$display("done: mode 1");
		// mode 2 write through the serial link
		mode(2'b10);
		a = 8'(1 + $urandom % 127);
		d = $urandom;
		u_host_model.spi({16'h0, 1'b1, a[6:0], d}, 16, rx);
		check("m2 write", regs[a[6:0]], d);
		// mode 3 write then read back
		mode(2'b11);
		d = $urandom;
		c = crc_of({13'h0, 1'b1, a[6:0], d, 3'b000}, 19);
		u_host_model.spi({8'h0, 1'b1, a[6:0], d, 3'b000, c}, 24, rx);
		st = {summary, low, missing, common};
		check("m3 wr reply", rx, {8'h0, st[10:3], 8'h00, st[2:0],
			crc_of({13'h0, st[10:3], 8'h00, st[2:0]}, 19)});
		check("m3 write", regs[a[6:0]], d);
		c = crc_of({13'h0, 1'b0, a[6:0], 11'h000}, 19);
		r0 = rd_cnt;
		u_host_model.spi({8'h0, 1'b0, a[6:0], 11'h000, c}, 24, rx);
		check("m3 fetch strobe", rd_cnt - r0, 1);
		check("m3 rd reply", rx, {8'h0, st[10:3], d, st[2:0],
			crc_of({13'h0, st[10:3], d, st[2:0]}, 19)});
		check("m3 ok", fail_n, 1'b1);
		$display("done: mode 2 and 3");
		// hold reset through the strobes, then direct mode again
		iface_sel <= 1'b0;
		u_host_model.hold(2600);
		check("hold reset", pwr, 8'h00);
		d = $urandom;
		u_host_model.direct(d);
		check("direct again", pwr, d);
		u_host_model.idle();
		$display("done: reset hold");
		final_report();
	end
endmodule
